// ### verilog/ddrwm_pkg.sv
package ddrwm_pkg;
    // Widths and lane layout
    localparam int WIDTH_DEF      = 36;
    localparam int NIBBLE_BITS    = 4;
    localparam int LANE_BITS      = 9;
    localparam int NIBBLE_MASKS   = 2;
    localparam int BYTE_MASKS     = 4;
    localparam int BURST_WORDS    = 2;
    localparam int ADDR_W_DEF     = 8;
    localparam int FIFO_DEPTH_DEF = 4;
    localparam int WIDTH_NIBBLE   = 8;
    // Direction select encoding
    localparam logic DIR_READ     = 1'b1;
    localparam logic DIR_WRITE    = 1'b0;
    // Burst beat positions
    localparam logic BEAT_FIRST   = 1'b0;
    localparam logic BEAT_SECOND  = 1'b1;

    // One captured write beat: data plus active-low lane masks
    typedef struct packed {
        logic [WIDTH_DEF-1:0]  data;
        logic [BYTE_MASKS-1:0] mask_n;
        logic                  beat;
    } ddrwm_beat_t;
endpackage : ddrwm_pkg

// ### verilog/ddrwm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ddrwm_fifo
    import ddrwm_pkg::*;
#(
    parameter int WIDTH = 41,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    ////////////////////////////////////////////////////////////////
    always_comb begin
        in_ready  = (cnt_reg != (PW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data  = mem_reg[rd_reg];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        mem_next  = mem_reg;
        wr_next   = wr_reg;
        rd_next   = rd_reg;
        if (push) begin
            mem_next[wr_reg] = in_data;
            wr_next          = bump(wr_reg);
        end
        if (pop) begin
            rd_next = bump(rd_reg);
        end
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            mem_reg <= mem_next;
        end
    end
endmodule : ddrwm_fifo
`default_nettype wire

// ### verilog/ddrwm_core.sv
`timescale 1ns/1ps
`default_nettype none
module ddrwm_core
    import ddrwm_pkg::*;
#(
    parameter int WIDTH  = WIDTH_DEF,
    parameter int ADDR_W = ADDR_W_DEF
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire ddrwm_beat_t       wr_beat,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic [WIDTH-1:0]       rd_data
);
    localparam int DEPTH = 2 ** ADDR_W;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [WIDTH-1:0] merged;

    // Lane select for one data bit under nibble or byte masks
    function automatic logic bit_kept(input int b, input logic [BYTE_MASKS-1:0] m);
        if (WIDTH == WIDTH_NIBBLE) begin
            bit_kept = m[b / NIBBLE_BITS];
        end else begin
            bit_kept = m[b / LANE_BITS];
        end
    endfunction : bit_kept

    ////////////////////////////////////////////////////////////////
    always_comb begin
        merged = mem_reg[wr_addr];
        for (int b = 0; b < WIDTH; b++) begin
            if (!bit_kept(b, wr_beat.mask_n)) begin // [R7] [R9] [R13]
                merged[b] = wr_beat.data[b];
            end
        end
        mem_next = mem_reg;
        if (wr_en) begin
            mem_next[wr_addr] = merged;
        end
        rd_data = mem_reg[rd_addr];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end
endmodule : ddrwm_core
`default_nettype wire

// ### verilog/ddrwm_port.sv
// Functional notes
// [R1] Write data sampled on rising edge of both input timing phases.
// [R2] Read data launched on output timing phases, or input phases in single mode.
// [R3] Read data drivers released whenever no read is selected.
// [R4] Address and direction registered only while load_n is low.
// [R5] Every transaction moves exactly two words.
// [R6] Nibble masks sampled with each write word in 8-bit build.
// [R7] Nibble mask 0 covers bits 3:0, mask 1 bits 7:4; high keeps.
// [R8] Byte masks sampled with each write word in wider builds.
// [R9] Byte masks cover 9-bit lanes 0 to 3; high keeps stored lane.
// [R10] Direction high reads, low writes, at load.
// [R11] Every access starts on an input positive-phase rising edge.
// [R12] First write word on positive phase, second on next complement.
// [R13] Width is 8, 9, 18 or 36; nibble masks only at 8.
`timescale 1ns/1ps
`default_nettype none
module ddrwm_port
    import ddrwm_pkg::*;
#(
    parameter int WIDTH      = WIDTH_DEF,
    parameter int ADDR_W     = ADDR_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // Timing phases, sampled as enables
    input  wire logic                    in_pos_edge,
    input  wire logic                    in_neg_edge,
    input  wire logic                    out_pos_edge,
    input  wire logic                    out_neg_edge,
    input  wire logic                    single_timing,
    // Command
    input  wire logic                    load_n,
    input  wire logic                    direction_sel,
    input  wire logic [ADDR_W-1:0]       addr,
    // Write data and masks
    input  wire logic [WIDTH-1:0]        write_input,
    input  wire logic [NIBBLE_MASKS-1:0] nibble_mask_n,
    input  wire logic [BYTE_MASKS-1:0]   byte_mask_n,
    // Read data pins
    output logic [WIDTH-1:0]             read_output,
    output logic                         read_output_oe,
    // Status
    output logic                         write_stall
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WR    = 4'h2,
        ST_RD0   = 4'h4,
        ST_RD1   = 4'h8
    } ddrwm_state_t;

    localparam int BEAT_W = $bits(ddrwm_beat_t);

    ddrwm_state_t        state_reg, state_next;
    logic [ADDR_W-1:0]   addr_reg, addr_next;
    logic                wbeat_reg, wbeat_next;
    logic [WIDTH-1:0]    dout_reg, dout_next;
    logic                oe_reg, oe_next;
    logic                stall_reg, stall_next;
    logic                launch_pos, launch_neg;
    logic                cap_valid, cap_ready;
    ddrwm_beat_t         cap_beat;
    logic                fifo_valid;
    ddrwm_beat_t         fifo_beat;
    logic [BEAT_W-1:0]   fifo_raw;
    logic [ADDR_W-1:0]   wr_addr_q;
    logic [ADDR_W-1:0]   rd_addr;
    logic [WIDTH-1:0]    rd_data;
    logic                cmd_load;
    logic [1:0]          wr_words_reg, wr_words_next;
    logic [1:0]          rd_words_reg, rd_words_next;

    // Lane masks per build width
    function automatic logic [BYTE_MASKS-1:0] pick_mask(
        input logic [NIBBLE_MASKS-1:0] nm,
        input logic [BYTE_MASKS-1:0]   bm
    );
        if (WIDTH == WIDTH_NIBBLE) begin
            pick_mask = {2'h3, nm}; // [R6] [R13]
        end else begin
            pick_mask = bm; // [R8]
        end
    endfunction : pick_mask

    ////////////////////////////////////////////////////////////////
    // Launch phase choice
    always_comb begin
        launch_pos = single_timing ? in_pos_edge : out_pos_edge; // [R2]
        launch_neg = single_timing ? in_neg_edge : out_neg_edge; // [R2]
        cmd_load   = in_pos_edge && !load_n; // [R4] [R11]
    end

    ////////////////////////////////////////////////////////////////
    // Command and burst sequencing
    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        wbeat_next = wbeat_reg;
        dout_next  = dout_reg;
        oe_next    = oe_reg;
        stall_next = !cap_ready;
        cap_valid  = 1'b0;
        cap_beat   = '0;
        cap_beat.data   = WIDTH_DEF'(write_input);
        cap_beat.mask_n = pick_mask(nibble_mask_n, byte_mask_n);
        cap_beat.beat   = wbeat_reg;
        rd_addr    = addr_reg;
        case (state_reg)
            ST_IDLE: begin
                oe_next = 1'b0; // [R3]
                if (cmd_load) begin
                    addr_next  = addr; // [R4]
                    state_next = (direction_sel == DIR_READ) ? ST_RD0 : ST_WR; // [R10]
                    wbeat_next = BEAT_FIRST;
                end
            end
            ST_WR: begin
                // Word on the positive phase, then on the complement
                if ((wbeat_reg == BEAT_FIRST && in_pos_edge) ||
                    (wbeat_reg == BEAT_SECOND && in_neg_edge)) begin // [R1] [R12]
                    cap_valid = 1'b1;
                    if (wbeat_reg == BEAT_SECOND) begin
                        state_next = ST_IDLE; // [R5]
                    end
                    wbeat_next = ~wbeat_reg;
                end
            end
            ST_RD0: begin
                if (launch_pos) begin
                    dout_next  = rd_data; // [R2]
                    oe_next    = 1'b1;
                    state_next = ST_RD1;
                end
            end
            ST_RD1: begin
                rd_addr = addr_reg ^ ADDR_W'(1);
                if (launch_neg) begin
                    dout_next  = rd_data; // [R2] [R5]
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            addr_reg  <= '0;
            wbeat_reg <= BEAT_FIRST;
            dout_reg  <= '0;
            oe_reg    <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            wbeat_reg <= wbeat_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            stall_reg <= stall_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Words moved per burst, kept for the burst-length checks only
    always_comb begin
        wr_words_next = wr_words_reg;
        rd_words_next = rd_words_reg;
        if (state_reg == ST_IDLE && cmd_load) begin
            wr_words_next = 2'h0;
            rd_words_next = 2'h0;
        end
        if (cap_valid) begin
            wr_words_next = wr_words_reg + 2'h1;
        end
        if ((state_reg == ST_RD0 && launch_pos) || (state_reg == ST_RD1 && launch_neg)) begin
            rd_words_next = rd_words_reg + 2'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_words_reg <= 2'h0;
            rd_words_reg <= 2'h0;
        end else begin
            wr_words_reg <= wr_words_next;
            rd_words_reg <= rd_words_next;
        end
    end

    a_wr_two_words: assert property (@(posedge clock) disable iff (rst) // [R5]
        (state_reg == ST_WR && state_next == ST_IDLE) |-> wr_words_next == 2'(BURST_WORDS))
        else $error("write burst not two words");
    a_rd_word_count: assert property (@(posedge clock) disable iff (rst) // [R5]
        (state_reg == ST_RD1 && state_next == ST_IDLE) |-> rd_words_next == 2'(BURST_WORDS))
        else $error("read burst word count wrong");
    a_words_bounded: assert property (@(posedge clock) disable iff (rst) // [R5]
        wr_words_reg <= 2'(BURST_WORDS) && rd_words_reg <= 2'(BURST_WORDS))
        else $error("burst ran past two words");

    ////////////////////////////////////////////////////////////////
    // Beats queue toward the array; second beat goes to the paired word, addr_reg with bit 0 inverted
    ddrwm_fifo #(
        .WIDTH (BEAT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (cap_beat),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_raw)
    );

    always_comb begin
        fifo_beat = ddrwm_beat_t'(fifo_raw);
        wr_addr_q = addr_reg ^ ADDR_W'(fifo_beat.beat);
    end

    // Limitation: a new load before drain would retarget queued beats
    ddrwm_core #(
        .WIDTH  (WIDTH),
        .ADDR_W (ADDR_W)
    ) u_core (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (fifo_valid),
        .wr_addr (wr_addr_q),
        .wr_beat (fifo_beat),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    always_comb begin
        read_output    = dout_reg;
        read_output_oe = oe_reg;
        write_stall    = stall_reg;
    end

    ////////////////////////////////////////////////////////////////
    a_load_only_low: assert property (@(posedge clock) disable iff (rst) // [R4]
        (state_reg == ST_IDLE && state_next != ST_IDLE) |-> !load_n && in_pos_edge)
        else $error("command taken without load");
    a_dir_read: assert property (@(posedge clock) disable iff (rst) // [R10]
        (state_reg == ST_IDLE && cmd_load && direction_sel) |=> state_reg == ST_RD0)
        else $error("read direction not honoured");
    a_dir_write: assert property (@(posedge clock) disable iff (rst) // [R10]
        (state_reg == ST_IDLE && cmd_load && !direction_sel) |=> state_reg == ST_WR)
        else $error("write direction not honoured");
    a_oe_idle_off: assert property (@(posedge clock) disable iff (rst) // [R3]
        (state_reg == ST_IDLE) |=> !oe_reg)
        else $error("drivers on with no read");
    a_first_beat_pos: assert property (@(posedge clock) disable iff (rst) // [R12]
        (cap_valid && cap_beat.beat == BEAT_FIRST) |-> in_pos_edge)
        else $error("first word not on positive phase");
    a_second_beat_neg: assert property (@(posedge clock) disable iff (rst) // [R1] [R5]
        (cap_valid && cap_beat.beat == BEAT_SECOND) |-> in_neg_edge && state_next == ST_IDLE)
        else $error("second word wrong");
    a_rd_launch: assert property (@(posedge clock) disable iff (rst) // [R2]
        (state_reg == ST_RD0 && launch_pos) |=> oe_reg && state_reg == ST_RD1)
        else $error("read launch missed");
    a_rd_two_words: assert property (@(posedge clock) disable iff (rst) // [R5]
        (state_reg == ST_RD1 && launch_neg) |=> state_reg == ST_IDLE)
        else $error("read burst not two words");
    a_mask_pass: assert property (@(posedge clock) disable iff (rst) // [R6] [R8]
        cap_valid |-> cap_beat.mask_n == pick_mask(nibble_mask_n, byte_mask_n))
        else $error("mask not sampled with data");
    a_hold_when_busy: assert property (@(posedge clock) disable iff (rst) // [R4]
        (state_reg != ST_IDLE) |-> addr_next == addr_reg)
        else $error("address reloaded during a burst");
    a_no_cap_outside: assert property (@(posedge clock) disable iff (rst) // [R1]
        (state_reg != ST_WR) |-> !cap_valid)
        else $error("write word taken outside a write");
    a_oe_off_write: assert property (@(posedge clock) disable iff (rst) // [R3]
        (state_reg == ST_WR) |-> !oe_reg)
        else $error("drivers on during a write");
    a_word0_data: assert property (@(posedge clock) disable iff (rst) // [R2]
        (state_reg == ST_RD0 && launch_pos) |=> read_output == $past(rd_data))
        else $error("first read word not launched");
    a_word1_data: assert property (@(posedge clock) disable iff (rst) // [R2] [R5]
        (state_reg == ST_RD1 && launch_neg) |=> read_output == $past(rd_data))
        else $error("second read word not launched");
    a_single_hold: assert property (@(posedge clock) disable iff (rst) // [R2]
        (state_reg == ST_RD0 && single_timing && !in_pos_edge) |=> state_reg == ST_RD0)
        else $error("single mode launched off phase");
    a_pair_address: assert property (@(posedge clock) disable iff (rst) // [R5]
        (state_reg == ST_RD1) |-> rd_addr == (addr_reg ^ ADDR_W'(1)))
        else $error("second read word from wrong address");
    a_second_beat_odd: assert property (@(posedge clock) disable iff (rst) // [R12]
        (fifo_valid && fifo_beat.beat == BEAT_SECOND) |-> wr_addr_q == (addr_reg ^ ADDR_W'(1)))
        else $error("second write word to wrong address");
    a_upper_lanes_kept: assert property (@(posedge clock) disable iff (rst) // [R13]
        (cap_valid && WIDTH == WIDTH_NIBBLE) |-> cap_beat.mask_n[BYTE_MASKS-1:NIBBLE_MASKS] == '1)
        else $error("unused lanes not masked");
endmodule : ddrwm_port
`default_nettype wire

// ### sim/ddrwm_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddrwm_ctrl_model (
    // Clock and pace
    input  wire logic clock,
    input  wire logic slow,
    // Timing phase pulses
    output logic      in_pos_edge,
    output logic      in_neg_edge,
    output logic      out_pos_edge,
    output logic      out_neg_edge
);
    logic [2:0] ph_reg = 3'h0;
    ////////////////////////////////////////////////////////////////////////////
    // Free running, as the timing pairs never stop
    always @(negedge clock) begin
        ph_reg <= ph_reg + 3'h1;
    end
    // Complement rises half a period after the positive phase
    assign in_pos_edge  = slow ? (ph_reg == 3'h0) : (ph_reg[1:0] == 2'h0);
    assign in_neg_edge  = slow ? (ph_reg == 3'h4) : (ph_reg[1:0] == 2'h2);
    assign out_pos_edge = slow ? (ph_reg == 3'h1) : (ph_reg[1:0] == 2'h1);
    assign out_neg_edge = slow ? (ph_reg == 3'h5) : (ph_reg[1:0] == 2'h3);
endmodule : ddrwm_ctrl_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import ddrwm_pkg::*;
;
    logic        clock         = 1'b0;
    logic        rst           = 1'b1;
    logic        slow          = 1'b0;
    logic        single_timing = 1'b0;
    logic        load_n        = 1'b1;
    logic        direction_sel = 1'b0;
    logic [7:0]  addr          = 8'h00;
    logic [35:0] write_input   = 36'h0;
    logic [3:0]  mask_n        = 4'hF;
    logic [3:0]  ph;
    logic [35:0] rd_w;
    logic [7:0]  rd_n;
    logic        oe_w, oe_n, stall_w, stall_n;
    logic [35:0] exp_w [256];
    logic [7:0]  exp_n [256];
    int          fail_count    = 0;
    int          compares      = 0;

    always #10 clock = ~clock;

    ddrwm_ctrl_model i_ddrwm_ctrl_model (.clock(clock), .slow(slow), .in_pos_edge(ph[0]),
        .in_neg_edge(ph[1]), .out_pos_edge(ph[2]), .out_neg_edge(ph[3]));
    ddrwm_port i_ddrwm_port (.clock(clock), .rst(rst), .in_pos_edge(ph[0]), .in_neg_edge(ph[1]),
        .out_pos_edge(ph[2]), .out_neg_edge(ph[3]), .single_timing(single_timing),
        .load_n(load_n), .direction_sel(direction_sel), .addr(addr), .write_input(write_input),
        .nibble_mask_n(2'h3), .byte_mask_n(mask_n), .read_output(rd_w),
        .read_output_oe(oe_w), .write_stall(stall_w));
    // Narrow build shares the command lines, so both widths see one stimulus
    ddrwm_port #(.WIDTH(8)) i_ddrwm_port_n8 (.clock(clock), .rst(rst), .in_pos_edge(ph[0]),
        .in_neg_edge(ph[1]), .out_pos_edge(ph[2]), .out_neg_edge(ph[3]),
        .single_timing(single_timing), .load_n(load_n), .direction_sel(direction_sel),
        .addr(addr), .write_input(write_input[7:0]), .nibble_mask_n(mask_n[1:0]),
        .byte_mask_n(4'hF), .read_output(rd_n), .read_output_oe(oe_n), .write_stall(stall_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // Bounded, so a missing pulse cannot hang the run
    task automatic wait_edge(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ph[k] !== 1'b1 && n < 40);
        if (n >= 40)
            fail_count++;
    endtask : wait_edge

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                          input logic [3:0] m, input int w);
        for (int b = 0; b < w; b++)
            if (!m[b / (w == WIDTH_NIBBLE ? NIBBLE_BITS : LANE_BITS)])
                old[b] = d[b];
        return old;
    endfunction : merge
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
        @(negedge clock);
        addr = a;
        direction_sel = DIR_WRITE;
        load_n = 1'b0;
        wait_edge(0);
        @(negedge clock);
        load_n = 1'b1;
        write_input = d0;
        mask_n = m0;
        wait_edge(0);
        @(negedge clock);
        write_input = d1;
        mask_n = m1;
        wait_edge(1);
        exp_w[a] = merge(exp_w[a], d0, m0, 36);
        exp_n[a] = 8'(merge({28'h0, exp_n[a]}, d0, m0, 8));
        exp_w[a ^ 8'h01] = merge(exp_w[a ^ 8'h01], d1, m1, 36);
        exp_n[a ^ 8'h01] = 8'(merge({28'h0, exp_n[a ^ 8'h01]}, d1, m1, 8));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic st);
        int k;
        k = st ? 0 : 2;
        @(negedge clock);
        single_timing = st;
        addr = a;
        direction_sel = DIR_READ;
        load_n = 1'b0;
        wait_edge(0);
        @(negedge clock);
        load_n = 1'b1;
        wait_edge(k);
        @(posedge clock);
        @(negedge clock);
        check(rd_w, exp_w[a]);
        check(36'({rd_n, oe_w, oe_n}), 36'({exp_n[a], 2'b11}));
        wait_edge(k + 1);
        @(posedge clock);
        @(negedge clock);
        check(rd_w, exp_w[a ^ 8'h01]);
        check(36'(rd_n), 36'(exp_n[a ^ 8'h01]));
        repeat (3) @(negedge clock);
        check(36'({oe_w, oe_n}), 36'h0);
    endtask : rd

    task automatic t_masks;
        for (int i = 0; i < 5; i++) begin
            wr(8'h20, ~exp_w[8'h20], ~exp_w[8'h21], ~(4'h1 << i), ~(4'h8 >> i));
            rd(8'h20, 1'b0);
        end
    endtask : t_masks

    task automatic t_noload;
        @(negedge clock);
        addr = 8'h20;
        direction_sel = DIR_WRITE;
        write_input = 36'hFFFFFFFFF;
        mask_n = 4'h0;
        repeat (12) @(negedge clock);
        check(36'({oe_w, oe_n}), 36'h0);
        rd(8'h20, 1'b0);
    endtask : t_noload
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            exp_w[i] = 36'h0;
            exp_n[i] = 8'h00;
        end
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check(rd_w, 36'h0);
        check(36'({rd_n, oe_w, stall_w, oe_n, stall_n}), 36'h0);
        rd(8'h50, 1'b0);
        wr(8'h20, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
        wr(8'h31, 36'hA5A5A5A5A, 36'h5A5A5A5A5, 4'h0, 4'h0);
        rd(8'h20, 1'b0);
        rd(8'h31, 1'b0);
        t_masks;
        t_noload;
        slow = 1'b1;
        wr(8'h42, 36'h0F0F0F0F0, 36'hC3C3C3C3C, 4'h0, 4'h0);
        rd(8'h42, 1'b1);
        rd(8'h30, 1'b1);
        check(36'({stall_w, stall_n}), 36'h0);
        conclude;
    end

    // Whole sequence needs about 250 cycles
    initial begin
        #300000;
        fail_count++;
        conclude;
    end
endmodule : tb
`default_nettype wire
